// ---- design/ectci_top.sv ----
// Eight-bit timer counter, channel 1 compare and shared interrupt flag bank
`timescale 1ns/1ps
`include "ectci_params.svh"

// Notes on behaviour
// (RULE1) Channel 0 level register, read/write, resets zero
// (RULE2) Channel 1 level register, read/write, resets zero
// (RULE3) Channel 1 mask bit 6, resets one
// (RULE4) Match: set, clear or toggle output
// (RULE5) Code 011: set up-match, clear zero/down-match
// (RULE6) Code 100: clear up-match, set zero/down-match
// (RULE7) 101/110 use channel 0 match; 111 idle
// (RULE8) Bit 2 enables channel 1 compare
// (RULE9) Software writes zero to bits 1:0
// (RULE10) Flag bits 5..3 for this timer
// (RULE11) Flag bits 2..0 for sibling timer
// (RULE12) Bit 6 wrap mask resets one; bit 7 zero
// (RULE13) Up/down and modulo bounded by channel 0 level
// (RULE14) Events set flags; write zero clears
module ectci_top (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  input  wire logic       count_tick,
  input  wire logic       count_clear,
  input  wire logic [1:0] count_mode,
  input  wire logic       b_chan0_event,
  input  wire logic       a_chan1_event,
  input  wire logic       a_chan0_event,
  input  wire logic       a_overflow_event,
  output logic [7:0]      sfr_rdata,
  output logic [7:0]      count_value,
  output logic            counting_down,
  output logic            chan1_out,
  output logic            chan1_irq_mask,
  output logic            wrap_irq_mask,
  output logic [5:0]      pending_flags
);

  ectci_pkg::ectci_top_state_t  state;
  ectci_pkg::ectci_top_state_t  next_state;
  ectci_pkg::ectci_count_mode_t mode;
  logic                         wr_flags;
  logic                         own_match;
  logic                         ch0_match;
  logic                         at_zero;
  logic [5:0]                   set_vec;
  logic [5:0]                   keep_vec;
  logic                         out_level;

  assign mode      = ectci_pkg::ectci_count_mode_t'(count_mode);
  assign wr_flags  = sfr_wr && (sfr_addr == `ECTCI_ADDR_IRQ_FLAG_BANK);
  // Compares look at the count already stepped, not the one being loaded
  assign own_match = (state.count == state.level1);
  assign ch0_match = (state.count == state.level0);
  assign at_zero   = (state.count == `ECTCI_COUNT_ZERO);

  always_comb begin
    next_state         = state;
    next_state.counted = 1'b0;
    next_state.ovf_evt = 1'b0;
    next_state.ch1_evt = 1'b0;

    // Counter; compare is evaluated the cycle after each step
    if (count_clear) begin
      next_state.count    = `ECTCI_COUNT_ZERO;
      next_state.dir_down = 1'b0;
    end else if (count_tick) begin
      next_state.counted = 1'b1;
      case (mode)
        ectci_pkg::ECTCI_MODE_FREE: begin
          // Rolling over from the top value is the overflow event
          next_state.count = state.count + 8'h01;
          if (state.count == `ECTCI_COUNT_TOP) next_state.ovf_evt = 1'b1;
        end
        ectci_pkg::ECTCI_MODE_DOWN: begin
          // Underflow reloads from the channel 0 level
          if (at_zero) begin
            next_state.count   = state.level0;
            next_state.ovf_evt = 1'b1;
          end else begin
            next_state.count = state.count - 8'h01;
          end
        end
        ectci_pkg::ECTCI_MODE_MODULO: begin
          // Compared with >= so a level lowered under the count still wraps
          if (state.count >= state.level0) begin // see (RULE13)
            next_state.count   = `ECTCI_COUNT_ZERO;
            next_state.ovf_evt = 1'b1;
          end else begin
            next_state.count = state.count + 8'h01;
          end
        end
        ectci_pkg::ECTCI_MODE_UPDOWN: begin
          if (!state.dir_down) begin
            if (state.count >= state.level0) begin // see (RULE13)
              // A zero level would otherwise wrap below zero
              next_state.dir_down = (state.level0 != `ECTCI_COUNT_ZERO);
              next_state.count    = next_state.dir_down ? state.count - 8'h01
                                                        : `ECTCI_COUNT_ZERO;
              next_state.ovf_evt  = !next_state.dir_down;
            end else begin
              next_state.count = state.count + 8'h01;
            end
          end else begin
            next_state.count = state.count - 8'h01;
            if (state.count <= 8'h01) begin // see (RULE13)
              next_state.count    = `ECTCI_COUNT_ZERO;
              next_state.dir_down = 1'b0;
              next_state.ovf_evt  = 1'b1;
            end
          end
        end
        default: begin
          next_state.count = state.count;
        end
      endcase
    end

    // Channel 1 flag trails the output by one edge; masks only go out on ports
    if (state.counted && state.ctl[`ECTCI_CTL_ENABLE_BIT] && own_match) begin // see (RULE8)
      next_state.ch1_evt = 1'b1;
    end

    // Register writes
    if (sfr_wr) begin
      case (sfr_addr)
        `ECTCI_ADDR_CH0_LEVEL: begin
          next_state.level0 = sfr_wdata; // see (RULE1)
        end
        `ECTCI_ADDR_CH1_LEVEL: begin
          next_state.level1 = sfr_wdata; // see (RULE2)
        end
        `ECTCI_ADDR_CH1_CONTROL: begin
          // Reserved low bits are stored as written; top bit never stored
          next_state.ctl = sfr_wdata & `ECTCI_CTL_STORED_MASK; // see (RULE3)
        end
        `ECTCI_ADDR_IRQ_FLAG_BANK: begin
          next_state.wrap_mask = sfr_wdata[`ECTCI_FLG_WRAP_MASK_BIT]; // see (RULE12)
        end
        default: begin
          // Unmapped writes leave every register alone
          next_state.level0 = state.level0;
        end
      endcase
    end

    // Flags: a one written keeps a flag, and a new event beats a clear
    set_vec = '0;
    set_vec[`ECTCI_FLG_B_CH1_BIT] = state.ch1_evt; // see (RULE10)
    set_vec[`ECTCI_FLG_B_CH0_BIT] = b_chan0_event;
    set_vec[`ECTCI_FLG_B_OVF_BIT] = state.ovf_evt;
    set_vec[`ECTCI_FLG_A_CH1_BIT] = a_chan1_event; // see (RULE11)
    set_vec[`ECTCI_FLG_A_CH0_BIT] = a_chan0_event;
    set_vec[`ECTCI_FLG_A_OVF_BIT] = a_overflow_event;
    keep_vec = wr_flags ? sfr_wdata[5:0] : 6'h3F;
    next_state.flags = (state.flags & keep_vec) | set_vec; // see (RULE14)

    // Registered read data; unmapped addresses read zero
    if (sfr_rd) begin
      case (sfr_addr)
        `ECTCI_ADDR_CH0_LEVEL: begin
          next_state.rdata = state.level0; // see (RULE1)
        end
        `ECTCI_ADDR_CH1_LEVEL: begin
          next_state.rdata = state.level1; // see (RULE2)
        end
        `ECTCI_ADDR_CH1_CONTROL: begin
          next_state.rdata = state.ctl;
        end
        `ECTCI_ADDR_IRQ_FLAG_BANK: begin
          next_state.rdata = {1'b0, state.wrap_mask, state.flags}; // see (RULE12)
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Mask bits come out of reset at one, so interrupts start enabled
      state           <= '0;
      state.level0    <= `ECTCI_RST_LEVEL; // see (RULE1)
      state.level1    <= `ECTCI_RST_LEVEL; // see (RULE2)
      state.ctl       <= `ECTCI_RST_CONTROL; // see (RULE3)
      state.flags     <= `ECTCI_RST_FLAGS; // see (RULE11)
      state.wrap_mask <= `ECTCI_RST_WRAP_MASK; // see (RULE12)
    end else begin
      state <= next_state;
    end
  end

  // Output action lands one edge after the counter step
  ectci_chan1_out ectci_chan1_out_i (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .eval          (state.counted),
    .enable        (state.ctl[`ECTCI_CTL_ENABLE_BIT]),
    .action        (ectci_pkg::ectci_action_t'(
                      state.ctl[`ECTCI_CTL_ACTION_MSB:`ECTCI_CTL_ACTION_LSB])),
    .own_match     (own_match),
    .ch0_match     (ch0_match),
    .at_zero       (at_zero),
    .counting_down (state.dir_down),
    .updown        (mode == ectci_pkg::ECTCI_MODE_UPDOWN),
    .out_level     (out_level)
  );

  // Every output is a register bit with no logic behind the flop
  assign sfr_rdata      = state.rdata;
  assign count_value    = state.count;
  assign counting_down  = state.dir_down;
  assign chan1_out      = out_level;
  assign chan1_irq_mask = state.ctl[`ECTCI_CTL_IRQ_MASK_BIT];
  assign wrap_irq_mask  = state.wrap_mask;
  assign pending_flags  = state.flags;

endmodule

// ---- design/ectci_params.svh ----
// Register offsets, field positions and reset values of the timer compare block
`ifndef ECTCI_PARAMS_SVH
`define ECTCI_PARAMS_SVH

`define ECTCI_ADDR_IRQ_FLAG_BANK   8'hD8
`define ECTCI_ADDR_CH0_LEVEL       8'hED
`define ECTCI_ADDR_CH1_CONTROL     8'hEE
`define ECTCI_ADDR_CH1_LEVEL       8'hEF

`define ECTCI_CTL_IRQ_MASK_BIT     6
`define ECTCI_CTL_ACTION_MSB       5
`define ECTCI_CTL_ACTION_LSB       3
`define ECTCI_CTL_ENABLE_BIT       2
`define ECTCI_CTL_STORED_MASK      8'h7F

`define ECTCI_FLG_WRAP_MASK_BIT    6
`define ECTCI_FLG_B_CH1_BIT        5
`define ECTCI_FLG_B_CH0_BIT        4
`define ECTCI_FLG_B_OVF_BIT        3
`define ECTCI_FLG_A_CH1_BIT        2
`define ECTCI_FLG_A_CH0_BIT        1
`define ECTCI_FLG_A_OVF_BIT        0

`define ECTCI_RST_LEVEL            8'h00
`define ECTCI_RST_CONTROL          8'h40
`define ECTCI_RST_FLAGS            6'h00
`define ECTCI_RST_WRAP_MASK        1'h1
`define ECTCI_COUNT_TOP            8'hFF
`define ECTCI_COUNT_ZERO           8'h00

`endif

// ---- design/ectci_pkg.sv ----
// Types shared by the timer compare block
package ectci_pkg;

  typedef enum logic [2:0] {
    ECTCI_ACT_SET        = 3'b000,
    ECTCI_ACT_CLEAR      = 3'b001,
    ECTCI_ACT_TOGGLE     = 3'b010,
    ECTCI_ACT_SET_UP     = 3'b011,
    ECTCI_ACT_CLEAR_UP   = 3'b100,
    ECTCI_ACT_SET_CH0CLR = 3'b101,
    ECTCI_ACT_CLR_CH0SET = 3'b110,
    ECTCI_ACT_UNUSED     = 3'b111
  } ectci_action_t;

  typedef enum logic [1:0] {
    ECTCI_MODE_FREE   = 2'b00,
    ECTCI_MODE_DOWN   = 2'b01,
    ECTCI_MODE_MODULO = 2'b10,
    ECTCI_MODE_UPDOWN = 2'b11
  } ectci_count_mode_t;

  typedef struct packed {
    logic out_level;
  } ectci_out_state_t;

  typedef struct packed {
    logic [7:0] level0;
    logic [7:0] ctl;
    logic [7:0] level1;
    logic [5:0] flags;
    logic       wrap_mask;
    logic [7:0] count;
    logic       dir_down;
    logic       counted;
    logic       ovf_evt;
    logic       ch1_evt;
    logic [7:0] rdata;
  } ectci_top_state_t;

endpackage

// ---- design/ectci_chan1_out.sv ----
// Channel 1 compare output action logic
`timescale 1ns/1ps
module ectci_chan1_out (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   eval,
  input  wire logic                   enable,
  input  wire ectci_pkg::ectci_action_t action,
  input  wire logic                   own_match,
  input  wire logic                   ch0_match,
  input  wire logic                   at_zero,
  input  wire logic                   counting_down,
  input  wire logic                   updown,
  output logic                        out_level
);

  ectci_pkg::ectci_out_state_t state;
  ectci_pkg::ectci_out_state_t next_state;

  always_comb begin
    next_state = state;
    if (eval && enable) begin // see (RULE8)
      case (action)
        ectci_pkg::ECTCI_ACT_SET: begin
          if (own_match) next_state.out_level = 1'b1; // see (RULE4)
        end
        ectci_pkg::ECTCI_ACT_CLEAR: begin
          if (own_match) next_state.out_level = 1'b0; // see (RULE4)
        end
        ectci_pkg::ECTCI_ACT_TOGGLE: begin
          if (own_match) next_state.out_level = ~state.out_level; // see (RULE4)
        end
        ectci_pkg::ECTCI_ACT_SET_UP: begin
          if (own_match && !counting_down) next_state.out_level = 1'b1; // see (RULE5)
          else if (updown && own_match && counting_down) next_state.out_level = 1'b0;
          else if (!updown && at_zero) next_state.out_level = 1'b0; // see (RULE5)
        end
        ectci_pkg::ECTCI_ACT_CLEAR_UP: begin
          if (own_match && !counting_down) next_state.out_level = 1'b0; // see (RULE6)
          else if (updown && own_match && counting_down) next_state.out_level = 1'b1;
          else if (!updown && at_zero) next_state.out_level = 1'b1; // see (RULE6)
        end
        ectci_pkg::ECTCI_ACT_SET_CH0CLR: begin
          // Own match wins when both levels are equal
          if (own_match) next_state.out_level = 1'b1; // see (RULE7)
          else if (ch0_match) next_state.out_level = 1'b0;
        end
        ectci_pkg::ECTCI_ACT_CLR_CH0SET: begin
          if (own_match) next_state.out_level = 1'b0; // see (RULE7)
          else if (ch0_match) next_state.out_level = 1'b1;
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign out_level = state.out_level;

endmodule

// ---- tb/ectci_top_properties.sv ----
// Port assertions for the timer compare block
`timescale 1ns/1ps
module ectci_top_properties (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic       b_chan0_event,
  input wire logic       a_chan1_event,
  input wire logic       a_chan0_event,
  input wire logic [7:0] sfr_rdata,
  input wire logic       chan1_out,
  input wire logic       chan1_irq_mask,
  input wire logic       wrap_irq_mask,
  input wire logic [5:0] pending_flags
);
  logic en_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadow of the compare enable, so output moves can be tied to it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_q <= 1'b0;
    end else if (sfr_wr && sfr_addr == 8'hEE) begin
      en_q <= sfr_wdata[2];
    end
  end
  sequence wr_at(a);
    sfr_wr && sfr_addr == a;
  endsequence
  sequence rd_at(a);
    sfr_rd && sfr_addr == a;
  endsequence
  chk_lvl0_readback: assert property (wr_at(8'hED) ##1 rd_at(8'hED) ##1 !sfr_rd
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("level0 readback wrong");
  chk_lvl1_readback: assert property (wr_at(8'hEF) ##1 rd_at(8'hEF) ##1 !sfr_rd
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("level1 readback wrong");
  chk_rdata_holds: assert property (!sfr_rd ##1 !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  chk_ch1_mask_wr: assert property (wr_at(8'hEE) |=> chan1_irq_mask == $past(sfr_wdata[6]))
    else $error("channel mask wrong");
  chk_wrap_mask_wr: assert property (wr_at(8'hD8) |=> wrap_irq_mask == $past(sfr_wdata[6]))
    else $error("wrap mask wrong");
  chk_top_bit_zero: assert property ((rd_at(8'hEE) or rd_at(8'hD8)) ##1 !sfr_rd
    |=> !sfr_rdata[7]) else $error("unused bit read one");
  chk_out_needs_en: assert property ($changed(chan1_out) |-> $past(en_q) || $past(en_q, 2))
    else $error("output moved while disabled");
  chk_this_flag_set: assert property (b_chan0_event |-> ##[1:2] pending_flags[4])
    else $error("channel 0 flag not set");
  chk_sib_flag_set: assert property (a_chan1_event |-> ##[1:2] pending_flags[2])
    else $error("sibling flag not set");
  chk_flag_no_spur: assert property ($rose(pending_flags[1])
    |-> $past(a_chan0_event) || $past(a_chan0_event, 2)) else $error("flag set without event");
  cover property ($rose(chan1_out));
  cover property ($rose(pending_flags[5]));
  cover property (wr_at(8'hD8));
endmodule

bind ectci_top ectci_top_properties ectci_top_properties_i (.sys_clk, .reset, .sfr_addr,
  .sfr_wr, .sfr_wdata, .sfr_rd, .b_chan0_event, .a_chan1_event, .a_chan0_event, .sfr_rdata,
  .chan1_out, .chan1_irq_mask, .wrap_irq_mask, .pending_flags);

// ---- tb/ectci_top_bench.sv ----
// Self-checking bench for the timer compare block
`timescale 1ns/1ps
module ectci_top_bench;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       count_tick = 1'b0;
  logic       count_clear = 1'b0;
  logic [1:0] count_mode = 2'b00;
  logic [3:0] ev = 4'h0;
  logic [7:0] sfr_rdata;
  logic [7:0] count_value;
  logic       counting_down;
  logic       chan1_out;
  logic       chan1_irq_mask;
  logic       wrap_irq_mask;
  logic [5:0] pending_flags;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  ectci_top ectci_top_i (.sys_clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .count_tick, .count_clear, .count_mode, .b_chan0_event(ev[3]), .a_chan1_event(ev[2]),
    .a_chan0_event(ev[1]), .a_overflow_event(ev[0]), .sfr_rdata, .count_value,
    .counting_down, .chan1_out, .chan1_irq_mask, .wrap_irq_mask, .pending_flags);
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every drive lands 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    cyc(1);
    chk("sfr_rdata", exp, sfr_rdata);
  endtask
  task automatic restart;
    count_clear = 1'b1;
    cyc(1);
    count_clear = 1'b0;
  endtask
  // Output moves one edge after the last step; the check waits two edges
  task automatic tick(input int n, input logic exp);
    count_tick = 1'b1;
    cyc(n);
    count_tick = 1'b0;
    cyc(2);
    chk("chan1_out", {7'h00, exp}, {7'h00, chan1_out});
  endtask
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    cyc(4);
    reset = 1'b0;
    cyc(1);
    rd(8'hD8, 8'h40);
    rd(8'hED, 8'h00);
    rd(8'hEE, 8'h40);
    chk("chan1_irq_mask", 8'h01, {7'h00, chan1_irq_mask});
    chk("wrap_irq_mask", 8'h01, {7'h00, wrap_irq_mask});
    rd(8'hEF, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'hED, 8'hA5);
    rd(8'hED, 8'hA5);
    wr(8'hEF, 8'h5A);
    rd(8'hEF, 8'h5A);
    wr(8'hEE, 8'hB8);
    rd(8'hEE, 8'h38);
    chk("chan1_irq_mask", 8'h00, {7'h00, chan1_irq_mask});
    wr(8'hD8, 8'h00);
    chk("wrap_irq_mask", 8'h00, {7'h00, wrap_irq_mask});
    cyc(1);
    wr(8'hD8, 8'hC0);
    rd(8'hD8, 8'h40);
    ev = 4'hF;
    cyc(1);
    ev = 4'h0;
    cyc(2);
    rd(8'hD8, 8'h57);
    wr(8'hD8, 8'h7E);
    rd(8'hD8, 8'h56);
    wr(8'hD8, 8'h40);
    rd(8'hD8, 8'h40);
    wr(8'hEF, 8'h03);
    cyc(1);
    wr(8'hED, 8'h05);
    for (int c = 0; c < 4; c++) begin
      wr(8'hEE, {2'b00, 3'(c == 3 ? 2 : c), 3'b100});
      restart();
      tick(3, c != 1 && c != 3);
    end
    chk("pending_flags", 8'h20, {2'b00, pending_flags});
    wr(8'hD8, 8'h40);
    cyc(1);
    wr(8'hEE, 8'h00);
    restart();
    tick(3, 1'b0);
    chk("pending_flags", 8'h00, {2'b00, pending_flags});
    wr(8'hEE, 8'h3C);
    restart();
    tick(3, 1'b0);
    wr(8'hEE, 8'h1C);
    restart();
    tick(3, 1'b1);
    tick(253, 1'b0);
    chk("pending_flags", 8'h28, {2'b00, pending_flags});
    wr(8'hEE, 8'h24);
    restart();
    tick(3, 1'b0);
    tick(253, 1'b1);
    count_mode = 2'b11;
    wr(8'hEE, 8'h1C);
    restart();
    tick(3, 1'b1);
    tick(4, 1'b0);
    chk("count_value", 8'h03, count_value);
    chk("counting_down", 8'h01, {7'h00, counting_down});
    wr(8'hEE, 8'h24);
    restart();
    tick(3, 1'b0);
    tick(4, 1'b1);
    count_mode = 2'b10;
    wr(8'hEE, 8'h2C);
    restart();
    tick(3, 1'b1);
    tick(2, 1'b0);
    tick(1, 1'b0);
    chk("count_value", 8'h00, count_value);
    wr(8'hEE, 8'h34);
    tick(3, 1'b0);
    tick(2, 1'b1);
    // Down mode: reload to level 5 overflows, then 4, 3 toggles
    count_mode = 2'b01;
    wr(8'hEE, 8'h14);
    cyc(1);
    wr(8'hD8, 8'h40);
    restart();
    tick(3, 1'b0);
    chk("count_value", 8'h03, count_value);
    chk("pending_flags", 8'h28, {2'b00, pending_flags});
    test_done();
  end
endmodule
